// file: wic_pkg.sv
// Constants, register map and types for the wakeup and interrupt control block
//
// Contract
// RULE1: Power-down always resumes in normal mode; only port pin changes end it.
// RULE2: Green mode resumes in the mode it left; pins or timer-0 overflow wake.
// RULE3: External oscillator wakeup from power-down waits 2048 oscillator clocks.
// RULE4: Internal RC oscillator wakeup from power-down waits 32 oscillator clocks.
// RULE5: Green mode wakeup inserts no settling delay.
// RULE6: Rising or falling edge on a wake-enabled pin triggers wakeup.
// RULE7: First-port pins always wake; second-port pins only when enabled.
// RULE8: Second-port wake enable is write-only, bits 3..0, reset zero.
// RULE9: Three sources: timer 0, timer/counter 0, external pin on port bit 0.
// RULE10: Taking an interrupt clears the global enable.
// RULE11: Return from interrupt sets the global enable again.
// RULE12: Taking an interrupt pushes one stack level and vectors to address 8.
// RULE13: Enable register bits 0, 4, 5 read/write, reset zero.
// RULE14: Request flags bits 0, 4, 5 set on events, reset zero.
// RULE15: Software clears request flags; vectoring leaves them alone.
// RULE16: No interrupt unless global enable, stack register bit 7, is one.
// RULE17: External pin event wakes from power-down into normal mode.
// RULE18: Software handles slow-to-normal switch and oscillator warm-up.
// RULE19: Power-down bit enters power-down and clears itself on wakeup.
// RULE20: Green bit enters green mode and clears itself on wakeup.
// RULE21: Request flags set regardless of the source enable.
// RULE22: Vector request needs flag and enable of one source plus global enable.
// RULE23: Pin changes detected by comparing synchronized sample with previous one.
package wic_pkg;
    localparam logic [7:0] WIC_ADDR_WAKE_EN  = 8'hC0;
    localparam logic [7:0] WIC_ADDR_IRQ_FLAG = 8'hC8;
    localparam logic [7:0] WIC_ADDR_IRQ_EN   = 8'hC9;
    localparam logic [7:0] WIC_ADDR_STACK    = 8'hDF;

    localparam int WIC_BIT_EXT   = 0;
    localparam int WIC_BIT_T0    = 4;
    localparam int WIC_BIT_TC0   = 5;
    localparam int WIC_BIT_GIE   = 7;
    localparam logic [7:0] WIC_IRQ_MASK   = 8'h31;
    localparam logic [7:0] WIC_WAKE_MASK  = 8'h0F;
    localparam logic [1:0] WIC_STACK_RST  = 2'h3;
    localparam logic [12:0] WIC_VECTOR    = 13'h0008;

    localparam int unsigned WIC_EXT_OSC_CLKS = 2048;
    localparam int unsigned WIC_RC_OSC_CLKS  = 32;
    localparam int WIC_CNT_W = 12;

    typedef enum logic [1:0] {
        WIC_RUN,
        WIC_POWERDOWN,
        WIC_GREEN,
        WIC_SETTLE
    } wic_state_e;
endpackage

// file: wic_wakeup_irq.sv
// Wakeup sequencing and three-source interrupt controller
`timescale 1ns/1ps
`default_nettype none
module wic_wakeup_irq
    import wic_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [7:0]  reg_rdata,
    // Mode control from the core
    input  wire logic        powerdown_request_bit,
    input  wire logic        green_request_bit,
    input  wire logic        slow_mode,
    input  wire logic        rc_oscillator_sel,
    input  wire logic        osc_clock_tick,
    output logic             powerdown_clear,
    output logic             green_clear,
    output logic             core_halted,
    output logic             resume_slow,
    // Pins and timer events
    input  wire logic [7:0]  port0_pins,
    input  wire logic [3:0]  port1_pins,
    input  wire logic        timer_zero_overflow,
    input  wire logic        timer_counter_zero_overflow,
    // Vectoring with the core
    input  wire logic        irq_taken,
    input  wire logic        return_from_irq,
    output logic             irq_request,
    output logic      [12:0] irq_vector,
    output logic             stack_push
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, second and third must agree
    logic [11:0] pin_s1_reg;
    logic [11:0] pin_s2_reg;
    logic [11:0] pin_s3_reg;
    logic [11:0] pin_prev_reg;
    logic [11:0] pin_stable;
    logic        pins_agree;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
        end else begin
            pin_s1_reg <= {port1_pins, port0_pins};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    assign pins_agree = (pin_s2_reg == pin_s3_reg);
    assign pin_stable = pins_agree ? pin_s3_reg : pin_prev_reg;

    logic prev_valid_reg;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_prev_reg   <= '0;
            prev_valid_reg <= 1'b0;
        end else begin
            pin_prev_reg   <= pin_stable;
            prev_valid_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [3:0] port1_wake_enable_reg;
    logic       ext_pin_irq_enable_reg;
    logic       timer0_irq_enable_reg;
    logic       timer_counter_irq_enable_reg;
    logic       ext_pin_irq_flag_reg;
    logic       timer0_irq_flag_reg;
    logic       timer_counter_irq_flag_reg;
    logic       global_irq_enable_reg;
    logic [1:0] stack_level_reg;

    wire hit_wake  = (reg_addr == WIC_ADDR_WAKE_EN);
    wire hit_flag  = (reg_addr == WIC_ADDR_IRQ_FLAG);
    wire hit_en    = (reg_addr == WIC_ADDR_IRQ_EN);
    wire hit_stack = (reg_addr == WIC_ADDR_STACK);
    wire wr_wake   = reg_write & hit_wake;
    wire wr_flag   = reg_write & hit_flag;
    wire wr_en     = reg_write & hit_en;
    wire wr_stack  = reg_write & hit_stack;

    // Wake change detect on synchronised samples
    wire [11:0] pin_diff   = prev_valid_reg ? (pin_stable ^ pin_prev_reg) : 12'h000; // RULE23 RULE6
    wire [11:0] wake_allow = {port1_wake_enable_reg, 8'hFF};                     // RULE7
    wire        pin_wake   = |(pin_diff & wake_allow);

    // External interrupt edge on port 0 bit 0, both directions
    wire ext_event = pin_diff[WIC_BIT_EXT];

    ////////////////////////////////////////////////////////////////////////
    // Mode sequencer
    wic_state_e state_reg;
    wic_state_e state_next;
    logic [WIC_CNT_W-1:0] settle_cnt_reg;
    logic [WIC_CNT_W-1:0] settle_cnt_next;
    logic                 green_slow_reg;

    wire [WIC_CNT_W-1:0] settle_limit = rc_oscillator_sel
        ? WIC_CNT_W'(WIC_RC_OSC_CLKS - 1)                                        // RULE4
        : WIC_CNT_W'(WIC_EXT_OSC_CLKS - 1);                                      // RULE3
    wire settle_done = osc_clock_tick && (settle_cnt_reg == settle_limit);

    // A clear pulse still in flight must not send the core straight back to sleep
    wire enter_pd    = powerdown_request_bit & ~powerdown_clear;
    wire enter_green = green_request_bit & ~green_clear & ~enter_pd;

    always_comb begin
        state_next      = state_reg;
        settle_cnt_next = settle_cnt_reg;
        unique case (state_reg)
            WIC_RUN: begin
                if (enter_pd) begin
                    state_next = WIC_POWERDOWN;                                  // RULE19
                end else if (enter_green) begin
                    state_next = WIC_GREEN;                                      // RULE20
                end
            end
            WIC_POWERDOWN: begin
                if (pin_wake) begin
                    state_next      = WIC_SETTLE;                                // RULE1 RULE17
                    settle_cnt_next = '0;
                end
            end
            WIC_GREEN: begin
                if (pin_wake || timer_zero_overflow) begin
                    state_next = WIC_RUN;                                        // RULE2 RULE5
                end
            end
            WIC_SETTLE: begin
                if (settle_done) begin
                    state_next = WIC_RUN;
                end else if (osc_clock_tick) begin
                    settle_cnt_next = settle_cnt_reg + 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg      <= WIC_RUN;
            settle_cnt_reg <= '0;
            green_slow_reg <= 1'b0;
        end else begin
            state_reg      <= state_next;
            settle_cnt_reg <= settle_cnt_next;
            if (state_reg == WIC_RUN && enter_green) begin
                green_slow_reg <= slow_mode;                                     // RULE2
            end
        end
    end

    wire pd_wake_now    = (state_reg == WIC_POWERDOWN) && pin_wake;
    wire green_wake_now = (state_reg == WIC_GREEN) && (pin_wake || timer_zero_overflow);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            powerdown_clear <= 1'b0;
            green_clear     <= 1'b0;
            resume_slow     <= 1'b0;
        end else begin
            powerdown_clear <= pd_wake_now;                                      // RULE19
            green_clear     <= green_wake_now;                                   // RULE20
            if (pd_wake_now) begin
                resume_slow <= 1'b0;                                             // RULE1
            end else if (green_wake_now) begin
                resume_slow <= green_slow_reg;                                   // RULE2
            end else if (state_reg == WIC_RUN) begin
                resume_slow <= slow_mode;
            end
        end
    end

    assign core_halted = (state_reg != WIC_RUN);

    ////////////////////////////////////////////////////////////////////////
    // Enables, flags, global enable and stack level
    wire take = irq_taken & irq_request;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            port1_wake_enable_reg        <= '0;                                  // RULE8
            ext_pin_irq_enable_reg       <= 1'b0;                                // RULE13
            timer0_irq_enable_reg        <= 1'b0;
            timer_counter_irq_enable_reg <= 1'b0;
        end else begin
            if (wr_wake) begin
                port1_wake_enable_reg <= reg_wdata[3:0];                         // RULE8
            end
            if (wr_en) begin
                ext_pin_irq_enable_reg       <= reg_wdata[WIC_BIT_EXT];          // RULE13
                timer0_irq_enable_reg        <= reg_wdata[WIC_BIT_T0];
                timer_counter_irq_enable_reg <= reg_wdata[WIC_BIT_TC0];
            end
        end
    end

    // Event set wins over a software clear in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ext_pin_irq_flag_reg       <= 1'b0;                                  // RULE14
            timer0_irq_flag_reg        <= 1'b0;
            timer_counter_irq_flag_reg <= 1'b0;
        end else begin
            if (ext_event) begin
                ext_pin_irq_flag_reg <= 1'b1;                                    // RULE14 RULE21 RULE9
            end else if (wr_flag) begin
                ext_pin_irq_flag_reg <= reg_wdata[WIC_BIT_EXT];                  // RULE15
            end
            if (timer_zero_overflow) begin
                timer0_irq_flag_reg <= 1'b1;                                     // RULE21
            end else if (wr_flag) begin
                timer0_irq_flag_reg <= reg_wdata[WIC_BIT_T0];
            end
            if (timer_counter_zero_overflow) begin
                timer_counter_irq_flag_reg <= 1'b1;                              // RULE21
            end else if (wr_flag) begin
                timer_counter_irq_flag_reg <= reg_wdata[WIC_BIT_TC0];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            global_irq_enable_reg <= 1'b0;                                       // RULE16
            stack_level_reg       <= WIC_STACK_RST;
        end else begin
            if (take) begin
                global_irq_enable_reg <= 1'b0;                                   // RULE10
                stack_level_reg       <= stack_level_reg - 1'b1;                 // RULE12
            end else if (return_from_irq) begin
                global_irq_enable_reg <= 1'b1;                                   // RULE11
                stack_level_reg       <= stack_level_reg + 1'b1;
            end else if (wr_stack) begin
                global_irq_enable_reg <= reg_wdata[WIC_BIT_GIE];
                stack_level_reg       <= reg_wdata[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Vector request
    wire any_pending = (ext_pin_irq_flag_reg & ext_pin_irq_enable_reg)
                     | (timer0_irq_flag_reg & timer0_irq_enable_reg)
                     | (timer_counter_irq_flag_reg & timer_counter_irq_enable_reg);

    assign irq_request = any_pending & global_irq_enable_reg                     // RULE22 RULE16
                       & (state_reg == WIC_RUN);
    assign irq_vector  = WIC_VECTOR;                                             // RULE12
    assign stack_push  = take;                                                   // RULE12

    ////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe; wake enable reads as zero
    wire [7:0] flag_word = {2'b00, timer_counter_irq_flag_reg, timer0_irq_flag_reg,
                            3'b000, ext_pin_irq_flag_reg};
    wire [7:0] en_word   = {2'b00, timer_counter_irq_enable_reg, timer0_irq_enable_reg,
                            3'b000, ext_pin_irq_enable_reg};
    wire [7:0] stk_word  = {global_irq_enable_reg, 5'b00000, stack_level_reg};
    wire [7:0] rd_mux    = hit_flag  ? flag_word :
                           hit_en    ? en_word   :
                           hit_stack ? stk_word  : 8'h00;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_read ? rd_mux : 8'h00;
        end
    end

endmodule
`default_nettype wire

// file: wic_sva.sv
// Concurrent checks on the wakeup and interrupt controller ports
`timescale 1ns/1ps
`default_nettype none
module wic_sva
    import wic_pkg::*;
(
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // Register port
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [7:0]  reg_rdata,
    // Mode control
    input wire logic        powerdown_request_bit,
    input wire logic        rc_oscillator_sel,
    input wire logic        osc_clock_tick,
    input wire logic        powerdown_clear,
    input wire logic        green_clear,
    input wire logic        core_halted,
    // Vectoring
    input wire logic        irq_request,
    input wire logic [12:0] irq_vector,
    input wire logic        stack_push
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic        settle_reg;
    logic        rc_reg;
    logic [11:0] tick_cnt_reg;
    logic [11:0] settle_need;
    assign settle_need = rc_reg ? 12'h020 : 12'h800;
    // Oscillator ticks seen between the power-down clear and the restart
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            settle_reg   <= 1'b0;
            rc_reg       <= 1'b0;
            tick_cnt_reg <= 12'h000;
        end else if (powerdown_clear) begin
            settle_reg   <= 1'b1;
            rc_reg       <= rc_oscillator_sel;
            tick_cnt_reg <= {11'h000, osc_clock_tick};
        end else if (!core_halted) begin
            settle_reg   <= 1'b0;
        end else if (osc_clock_tick) begin
            tick_cnt_reg <= tick_cnt_reg + 12'h001;
        end
    end
    property p_vector;
        stack_push |-> irq_request && irq_vector == 13'h0008;
    endproperty
    a_vector: assert property (p_vector) else $error("bad vector");
    property p_gie_clear;
        stack_push |=> !irq_request;
    endproperty
    a_gie_clear: assert property (p_gie_clear) else $error("request after take");
    property p_gie_gate;
        (reg_write && reg_addr == 8'hDF && !reg_wdata[7]) |=> !irq_request;
    endproperty
    a_gie_gate: assert property (p_gie_gate) else $error("request with gie off");
    property p_en_gate;
        (reg_write && reg_addr == 8'hC9 && (reg_wdata & 8'h31) == 8'h00) |=> !irq_request;
    endproperty
    a_en_gate: assert property (p_en_gate) else $error("request unenabled");
    property p_halt_no_irq;
        core_halted |-> !irq_request;
    endproperty
    a_halt_no_irq: assert property (p_halt_no_irq) else $error("request halted");
    property p_wo_read;
        (reg_read && reg_addr == 8'hC0) |=> reg_rdata == 8'h00;
    endproperty
    a_wo_read: assert property (p_wo_read) else $error("wake enable readable");
    property p_rsvd;
        (reg_read && reg_addr[7:1] == 7'h64) |=> (reg_rdata & 8'hCE) == 8'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_pd_enter;
        (powerdown_request_bit && !core_halted) |=> core_halted;
    endproperty
    a_pd_enter: assert property (p_pd_enter) else $error("no power-down");
    property p_pd_clear;
        powerdown_clear |-> core_halted ##1 !powerdown_clear;
    endproperty
    a_pd_clear: assert property (p_pd_clear) else $error("bad clear pulse");
    property p_green_fast;
        green_clear |-> !core_halted ##1 !core_halted;
    endproperty
    a_green_fast: assert property (p_green_fast) else $error("green slow");
    property p_settle;
        (settle_reg && !core_halted) |->
            tick_cnt_reg + 12'h002 >= settle_need && tick_cnt_reg <= settle_need + 12'h002;
    endproperty
    a_settle: assert property (p_settle) else $error("settle count");
endmodule
bind wic_wakeup_irq wic_sva u_wic_sva (.*);
`default_nettype wire

// file: wic_core_model.sv
// Core-side model: mode bits, oscillator ticks and vector acceptance
`timescale 1ns/1ps
`default_nettype none
module wic_core_model (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Bench commands
    input  wire logic cmd_pd,
    input  wire logic cmd_green,
    input  wire logic cmd_take,
    // Block side
    input  wire logic powerdown_clear,
    input  wire logic green_clear,
    input  wire logic core_halted,
    input  wire logic irq_request,
    output logic      powerdown_request_bit,
    output logic      green_request_bit,
    output logic      osc_clock_tick,
    output logic      irq_taken
);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            powerdown_request_bit <= 1'b0;
            green_request_bit     <= 1'b0;
        end else begin
            powerdown_request_bit <= cmd_pd | (powerdown_request_bit & ~powerdown_clear);
            green_request_bit     <= cmd_green | (green_request_bit & ~green_clear);
        end
    end
    // Oscillator ticks only while the core is halted and the power-down bit is clear
    assign osc_clock_tick = core_halted & ~powerdown_request_bit;
    assign irq_taken      = cmd_take & irq_request & ~core_halted;
endmodule
`default_nettype wire

// file: tb_wakeup_and_interrupt_control.sv
// Self-checking bench for the wakeup and interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb_wakeup_and_interrupt_control;
    import wic_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, port0_pins, v;
    logic [3:0] port1_pins;
    logic [12:0] irq_vector;
    logic reg_write, reg_read, slow_mode, rc_oscillator_sel, osc_clock_tick;
    logic timer_zero_overflow, timer_counter_zero_overflow, return_from_irq;
    logic cmd_pd, cmd_green, cmd_take, powerdown_request_bit, green_request_bit;
    logic powerdown_clear, green_clear, core_halted, resume_slow;
    logic irq_taken, irq_request, stack_push, rd_d = 1'b0;
    logic [7:0] exp_q[$];
    int n_fail = 0;
    int samples_checked = 0;
    int seed = 32'h745ef3fb;
    int cyc;
    wic_wakeup_irq u_wic_wakeup_irq (.*);
    wic_core_model u_wic_core_model (.*);
    initial begin
        forever #2 clock = ~clock;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    always @(posedge clock) begin
        if (rd_d) chk(reg_rdata, exp_q.pop_front());
        rd_d <= reg_read;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        {reg_addr, reg_read} <= {a, 1'b1};
        @(posedge clock);
        reg_read <= 1'b0;
        @(posedge clock);
    endtask
    task automatic ev(input int k);
        if (k == 0) timer_zero_overflow <= 1'b1;
        else if (k == 1) timer_counter_zero_overflow <= 1'b1;
        else return_from_irq <= 1'b1;
        @(posedge clock);
        {timer_zero_overflow, timer_counter_zero_overflow, return_from_irq} <= 3'h0;
        @(posedge clock);
    endtask
    task automatic mode(input logic pd, input int lim);
        {cmd_pd, cmd_green} <= {pd, ~pd};
        @(posedge clock);
        {cmd_pd, cmd_green} <= 2'h0;
        repeat (3) @(posedge clock);
        chk(core_halted, 1'b1);
    endtask
    task automatic wake_wait(input int lim);
        cyc = 0;
        while (core_halted === 1'b1 && cyc < lim) begin
            @(posedge clock);
            cyc++;
        end
    endtask
    task automatic conclude();
        $display("comparisons=%0d mismatches=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #60000;
        n_fail++;
        conclude();
    end
    initial begin
        {reg_addr, reg_wdata, reg_write, reg_read, slow_mode, rc_oscillator_sel} = '0;
        {port0_pins, port1_pins, timer_zero_overflow, timer_counter_zero_overflow} = '0;
        {return_from_irq, cmd_pd, cmd_green, cmd_take} = '0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        repeat (3) @(posedge clock);
        rd(8'hC8, 8'h00);
        rd(8'hC9, 8'h00);
        rd(8'hDF, 8'h03);
        rd(8'h55, 8'h00);
        v = 8'($random(seed));
        wr(8'hC9, v);
        rd(8'hC9, v & 8'h31);
        wr(8'hC0, v);
        rd(8'hC0, 8'h00);
        wr(8'hC9, 8'h00);
        ev(0);
        rd(8'hC8, 8'h10);
        ev(1);
        port0_pins <= 8'h01;
        repeat (6) @(posedge clock);
        rd(8'hC8, 8'h31);
        chk(irq_request, 1'b0);
        wr(8'hC8, 8'h00);
        rd(8'hC8, 8'h00);
        $display("registers and flags done");
        for (int s = 0; s < 3; s++) begin
            v = (s == 0) ? 8'h10 : (s == 1) ? 8'h20 : 8'h01;
            wr(8'hC9, v);
            wr(8'hDF, 8'h83);
            if (s == 2) port0_pins <= 8'h00;
            else ev(s);
            repeat (6) @(posedge clock);
            chk(irq_request, 1'b1);
            cmd_take <= 1'b1;
            #1 chk({stack_push, irq_vector}, 16'h2008);
            @(posedge clock);
            cmd_take <= 1'b0;
            @(posedge clock);
            chk(irq_request, 1'b0);
            rd(8'hDF, 8'h02);
            rd(8'hC8, v);
            ev(2);
            rd(8'hDF, 8'h83);
            chk(irq_request, 1'b1);
            wr(8'hDF, 8'h03);
            chk(irq_request, 1'b0);
            wr(8'hC8, 8'h00);
        end
        $display("interrupts done");
        {rc_oscillator_sel, slow_mode} <= 2'h3;
        wr(8'hC0, 8'h00);
        mode(1'b1, 0);
        port1_pins <= 4'h1;
        ev(0);
        repeat (10) @(posedge clock);
        chk(core_halted, 1'b1);
        port0_pins <= 8'h01 << ($random(seed) & 7);
        wake_wait(100);
        chk(cyc >= 32 && cyc <= 45, 1'b1);
        chk({resume_slow, powerdown_request_bit}, 2'b00);
        slow_mode <= 1'b0;
        rc_oscillator_sel <= 1'b0;
        wr(8'hC0, 8'h01);
        mode(1'b1, 0);
        port1_pins <= 4'h0;
        wake_wait(2200);
        chk(cyc >= 2048 && cyc <= 2062, 1'b1);
        $display("power-down done");
        for (int g = 0; g < 2; g++) begin
            slow_mode <= (g == 0);
            mode(1'b0, 0);
            if (g == 0) ev(0);
            else port0_pins <= 8'h00;
            wake_wait(12);
            chk(cyc <= 8, 1'b1);
            @(posedge clock);
            chk({resume_slow, green_request_bit}, (g == 0) ? 2'b10 : 2'b00);
        end
        $display("green done");
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        rd(8'hDF, 8'h03);
        $display("second reset done");
        conclude();
    end
endmodule
`default_nettype wire
